/* File: hw/usc_pkg.sv */
package usc_pkg;
	// register indexes; byte address is four times the index
	localparam logic [17:0] IDX_UNLOCK_KEY = 18'h318d0;
	localparam logic [17:0] IDX_COMMAND_CODE = 18'h318d1;
	localparam logic [17:0] IDX_SYSTEM_MODE_STATUS = 18'h318d2;
	localparam int ADDR_W = 20;
	localparam logic [31:0] UNLOCK_VALUE = 32'h424f6f74;
	// command codes
	localparam logic [31:0] CMD_RESTART = 32'd102;
	localparam logic [31:0] CMD_RESTORE_DEFAULTS = 32'd104;
	localparam logic [31:0] CMD_WAIT_OFF = 32'd122;
	localparam logic [31:0] CMD_WAIT_ON = 32'd123;
	localparam logic [31:0] CMD_TASKSW_OFF = 32'd160;
	localparam logic [31:0] CMD_TASKSW_ON = 32'd161;
	localparam logic [31:0] CMD_LOAD_ALL = 32'd310;
	localparam logic [31:0] CMD_LOAD_MODULE = 32'd311;
	localparam logic [31:0] CMD_LOAD_PD = 32'd312;
	localparam logic [31:0] CMD_STOP_PD = 32'd313;
	localparam logic [31:0] CMD_CLIENT_OFF = 32'd330;
	localparam logic [31:0] CMD_CLIENT_ON = 32'd331;
	localparam logic [31:0] CMD_MCB_OFF = 32'd410;
	localparam logic [31:0] CMD_MCB_ALL = 32'd411;
	localparam logic [31:0] CMD_MCB_PORT_B = 32'd412;
	// status bit positions
	localparam int ST_TASKSW = 0;
	localparam int ST_NO_WAIT = 1;
	localparam int ST_CLIENT = 2;
	localparam int ST_MCB = 8;
	// reset values of the mode bits
	localparam logic RST_TASKSW = 1'b0;
	localparam logic RST_WAIT = 1'b1;
	localparam logic RST_CLIENT = 1'b1;
	// multicast range: upper 40 bits of the destination address
	localparam logic [39:0] MC_PREFIX = 40'h01005e4000;
	// ports of the forwarding fabric
	localparam int PORT_CPU = 0;
	localparam int PORT_A = 1;
	localparam int PORT_B = 2;
	localparam int NPORT = 3;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int POLL_WIN_MS = 1;
	localparam int POLL_PERIOD_MS = 10;
	localparam int POLL_WIN_CYC = POLL_WIN_MS * 1000000 / CLK_PERIOD_NS;
	localparam int POLL_PERIOD_CYC = POLL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int POLL_CNT_W = 17;

	typedef enum logic [1:0] {
		MCB_OFF,
		MCB_ALL,
		MCB_PORT_B
	} usc_mcb_e;
endpackage : usc_pkg

/* File: hw/usc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: software writes unlock value before command
// RULE2: command acts only with correct key
// RULE3: key cleared after accepted command
// RULE4: command executed then register cleared
// RULE5: 102 restarts like power cycle
// RULE6: 104 restores retained parameter defaults
// RULE7: 122 serves partners only on request
// RULE8: 123 polls cyclically for 1 ms
// RULE9: status bit 1 high when not waiting
// RULE10: 160 suspends tasks during peripheral access
// RULE11: 161 keeps tasks running during access
// RULE12: status bit 0 shows task switching
// RULE13: 311 module, 312 data, 310 both loads
// RULE14: 313 halts process-data traffic
// RULE15: 330/331 discovery client, status bit 2
// RULE16: 410 clears blocking, forwards freely
// RULE17: blocking off after power-on
// RULE18: 411 blocks system multicast on all ports
// RULE19: other frames always forwarded normally
// RULE20: 412 restricts multicast around port B
// RULE21: multicast range is 256 fixed addresses
// RULE22: software checks status after command
// RULE23: unknown or unkeyed command does nothing
module usc_top #(
	parameter int POLL_WIN_CYC = usc_pkg::POLL_WIN_CYC,
	parameter int POLL_PERIOD_CYC = usc_pkg::POLL_PERIOD_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [usc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_comm_request,
	input wire logic i_periph_busy,
	input wire logic [usc_pkg::NPORT-1:0] i_frame_valid,
	input wire logic [usc_pkg::NPORT-1:0][47:0] i_frame_dst,
	output logic [usc_pkg::NPORT-1:0][usc_pkg::NPORT-1:0] o_fwd_mask,
	output logic [usc_pkg::NPORT-1:0] o_fwd_valid,
	output logic o_restart,
	output logic o_restore_defaults,
	output logic o_load_module_cfg,
	output logic o_load_pd_cfg,
	output logic o_stop_pd,
	output logic o_comm_serve,
	output logic o_suspend_tasks,
	output logic o_discovery_client_en,
	output logic o_discovery_server_en
);

	////////////////////////////////////////////////////////////////////////////
	// register decode

	logic [31:0] unlock_key_r, unlock_key_nxt;
	logic [31:0] command_code_r, command_code_nxt;
	logic exec_r, exec_ok_r;
	logic tasksw_r, wait_r, client_r;
	usc_pkg::usc_mcb_e mcb_r;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] status;

	wire sel_key = i_addr == {usc_pkg::IDX_UNLOCK_KEY, 2'b00};
	wire sel_cmd = i_addr == {usc_pkg::IDX_COMMAND_CODE, 2'b00};
	wire sel_st = i_addr == {usc_pkg::IDX_SYSTEM_MODE_STATUS, 2'b00};
	wire wr_key = i_wr && sel_key;
	wire wr_cmd = i_wr && sel_cmd;
	wire key_ok = unlock_key_r == usc_pkg::UNLOCK_VALUE;

	always_comb begin
		status = 32'h0;
		// RULE12: task switch bit
		status[usc_pkg::ST_TASKSW] = tasksw_r;
		// RULE9: not-waiting bit
		status[usc_pkg::ST_NO_WAIT] = ~wait_r;
		status[usc_pkg::ST_CLIENT] = client_r;
		status[usc_pkg::ST_MCB] = mcb_r != usc_pkg::MCB_OFF;
	end

	assign rdata_nxt = !i_rd ? 32'h0 :
		sel_key ? unlock_key_r :
		sel_cmd ? command_code_r :
		sel_st ? status : 32'h0;

	////////////////////////////////////////////////////////////////////////////
	// key and command registers

	// RULE3: key cleared after accepted command
	assign unlock_key_nxt = wr_key ? i_wdata : (exec_ok_r ? 32'h0 : unlock_key_r);
	// RULE4: clear after execution
	assign command_code_nxt = wr_cmd ? i_wdata : (exec_r ? 32'h0 : command_code_r);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			unlock_key_r <= 32'h0;
			command_code_r <= 32'h0;
			exec_r <= 1'b0;
			exec_ok_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			unlock_key_r <= unlock_key_nxt;
			command_code_r <= command_code_nxt;
			exec_r <= wr_cmd;
			// RULE2: accept only with key
			exec_ok_r <= wr_cmd && key_ok;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// command execution

	// RULE23: unkeyed or unknown ignored
	wire go = exec_ok_r;
	wire is_restart = go && command_code_r == usc_pkg::CMD_RESTART;
	wire is_load_all = command_code_r == usc_pkg::CMD_LOAD_ALL;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tasksw_r <= usc_pkg::RST_TASKSW;
			wait_r <= usc_pkg::RST_WAIT;
			client_r <= usc_pkg::RST_CLIENT;
			// RULE17: blocking off at power-on
			mcb_r <= usc_pkg::MCB_OFF;
		end else if (is_restart) begin
			// RULE5: restart restores power-on state
			tasksw_r <= usc_pkg::RST_TASKSW;
			wait_r <= usc_pkg::RST_WAIT;
			client_r <= usc_pkg::RST_CLIENT;
			mcb_r <= usc_pkg::MCB_OFF;
		end else if (go) begin
			case (command_code_r)
				// RULE7: wait off
				usc_pkg::CMD_WAIT_OFF: wait_r <= 1'b0;
				// RULE8: wait on
				usc_pkg::CMD_WAIT_ON: wait_r <= 1'b1;
				// RULE10: task switch off
				usc_pkg::CMD_TASKSW_OFF: tasksw_r <= 1'b0;
				// RULE11: task switch on
				usc_pkg::CMD_TASKSW_ON: tasksw_r <= 1'b1;
				// RULE15: discovery client mode
				usc_pkg::CMD_CLIENT_OFF: client_r <= 1'b0;
				usc_pkg::CMD_CLIENT_ON: client_r <= 1'b1;
				// RULE16: blocking off
				usc_pkg::CMD_MCB_OFF: mcb_r <= usc_pkg::MCB_OFF;
				// RULE18: block all ports
				usc_pkg::CMD_MCB_ALL: mcb_r <= usc_pkg::MCB_ALL;
				// RULE20: block toward port B
				usc_pkg::CMD_MCB_PORT_B: mcb_r <= usc_pkg::MCB_PORT_B;
				default: mcb_r <= mcb_r;
			endcase
		end
	end

	// one-cycle action pulses, registered
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_restart <= 1'b0;
			o_restore_defaults <= 1'b0;
			o_load_module_cfg <= 1'b0;
			o_load_pd_cfg <= 1'b0;
			o_stop_pd <= 1'b0;
		end else begin
			o_restart <= is_restart;
			// RULE6: restore defaults
			o_restore_defaults <= go && command_code_r == usc_pkg::CMD_RESTORE_DEFAULTS;
			// RULE13: configuration loads
			o_load_module_cfg <= go && (is_load_all ||
				command_code_r == usc_pkg::CMD_LOAD_MODULE);
			o_load_pd_cfg <= go && (is_load_all || command_code_r == usc_pkg::CMD_LOAD_PD);
			// RULE14: halt process data
			o_stop_pd <= go && command_code_r == usc_pkg::CMD_STOP_PD;
		end
	end

	assign o_discovery_client_en = client_r;
	assign o_discovery_server_en = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// communication polling and task suspension

	logic req_s1_r, req_s2_r;
	logic [usc_pkg::POLL_CNT_W-1:0] poll_cnt_r, poll_cnt_nxt;
	logic serve_r;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
		end else begin
			req_s1_r <= i_comm_request;
			req_s2_r <= req_s1_r;
		end
	end

	assign poll_cnt_nxt = (!wait_r || poll_cnt_r == usc_pkg::POLL_CNT_W'(POLL_PERIOD_CYC - 1)) ?
		'0 : poll_cnt_r + 1'b1;
	// RULE8: poll window each period
	wire poll_win = wait_r && poll_cnt_r < usc_pkg::POLL_CNT_W'(POLL_WIN_CYC);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			poll_cnt_r <= '0;
			serve_r <= 1'b0;
		end else begin
			poll_cnt_r <= poll_cnt_nxt;
			// RULE7: explicit request served
			serve_r <= poll_win || req_s2_r;
		end
	end

	assign o_comm_serve = serve_r;
	// RULE10: suspend while access busy
	assign o_suspend_tasks = i_periph_busy && !tasksw_r;

	////////////////////////////////////////////////////////////////////////////
	// multicast forwarding filter

	for (genvar p = 0; p < usc_pkg::NPORT; p++) begin : g_port
		// RULE21: range match
		wire is_mc = i_frame_dst[p][47:8] == usc_pkg::MC_PREFIX;
		logic [usc_pkg::NPORT-1:0] normal;
		logic [usc_pkg::NPORT-1:0] restricted;
		logic [usc_pkg::NPORT-1:0] mask_nxt;
		always_comb begin
			normal = '1;
			normal[p] = 1'b0;
			restricted = '0;
			if (p == usc_pkg::PORT_CPU) begin
				restricted[usc_pkg::PORT_A] = 1'b1;
			end else if (p == usc_pkg::PORT_A) begin
				restricted[usc_pkg::PORT_CPU] = 1'b1;
			end else begin
				restricted[usc_pkg::PORT_CPU] = 1'b1;
				restricted[usc_pkg::PORT_A] = 1'b1;
			end
		end
		// RULE19: others forward normally
		assign mask_nxt = !is_mc || mcb_r == usc_pkg::MCB_OFF ? normal :
			mcb_r == usc_pkg::MCB_PORT_B ? restricted : '0;
		always_ff @(posedge i_ref_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				o_fwd_mask[p] <= '0;
				o_fwd_valid[p] <= 1'b0;
			end else begin
				o_fwd_mask[p] <= i_frame_valid[p] ? mask_nxt : '0;
				o_fwd_valid[p] <= i_frame_valid[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	property p_unkeyed_no_action;
		wr_cmd && !key_ok |=> !exec_ok_r ##1 !o_restart && !o_restore_defaults && !o_stop_pd;
	endproperty
	a_unkeyed_no_action: assert property (p_unkeyed_no_action) // RULE2
		else $error("command acted without key");

	property p_key_cleared;
		wr_cmd && key_ok ##1 !wr_key |=> unlock_key_r == 32'h0;
	endproperty
	a_key_cleared: assert property (p_key_cleared) // RULE3
		else $error("key not cleared after command");

	property p_cmd_cleared;
		wr_cmd ##1 !wr_cmd |=> command_code_r == 32'h0;
	endproperty
	a_cmd_cleared: assert property (p_cmd_cleared) // RULE4
		else $error("command register not cleared");

	property p_restart;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_RESTART |=> ##1 o_restart
			&& mcb_r == usc_pkg::MCB_OFF && wait_r == usc_pkg::RST_WAIT;
	endproperty
	a_restart: assert property (p_restart) // RULE5
		else $error("restart did not restore power-on state");

	property p_wait_status;
		status[usc_pkg::ST_NO_WAIT] && !req_s2_r |=> !o_comm_serve;
	endproperty
	a_wait_status: assert property (p_wait_status) // RULE9
		else $error("wait status bit wrong");

	property p_suspend;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_TASKSW_OFF ##2 i_periph_busy
			|-> o_suspend_tasks;
	endproperty
	a_suspend: assert property (p_suspend) // RULE10
		else $error("tasks not suspended during access");

	property p_tasksw_status;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_TASKSW_ON |=> ##1
			status[usc_pkg::ST_TASKSW];
	endproperty
	a_tasksw_status: assert property (p_tasksw_status) // RULE12
		else $error("task switch bit not set");

	property p_load_all;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_LOAD_ALL |=> ##1
			o_load_module_cfg && o_load_pd_cfg;
	endproperty
	a_load_all: assert property (p_load_all) // RULE13
		else $error("load all did not load both");

	property p_block_all;
		mcb_r == usc_pkg::MCB_ALL && i_frame_valid[usc_pkg::PORT_B]
			&& i_frame_dst[usc_pkg::PORT_B][47:8] == usc_pkg::MC_PREFIX
			|=> o_fwd_valid[usc_pkg::PORT_B] && o_fwd_mask[usc_pkg::PORT_B] == 3'h0;
	endproperty
	a_block_all: assert property (p_block_all) // RULE18
		else $error("multicast forwarded while blocked");

	property p_other_frames;
		i_frame_valid[usc_pkg::PORT_CPU]
			&& i_frame_dst[usc_pkg::PORT_CPU][47:8] != usc_pkg::MC_PREFIX
			|=> o_fwd_mask[usc_pkg::PORT_CPU] == 3'h6;
	endproperty
	a_other_frames: assert property (p_other_frames) // RULE19
		else $error("ordinary frame not forwarded");

	property p_port_b_mode;
		mcb_r == usc_pkg::MCB_PORT_B && i_frame_valid[usc_pkg::PORT_A]
			&& i_frame_dst[usc_pkg::PORT_A][47:8] == usc_pkg::MC_PREFIX
			|=> o_fwd_mask[usc_pkg::PORT_A] == 3'h1;
	endproperty
	a_port_b_mode: assert property (p_port_b_mode) // RULE20
		else $error("port a multicast not sent to cpu only");

	property p_mcb_status;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_MCB_OFF |=> ##1
			!status[usc_pkg::ST_MCB];
	endproperty
	a_mcb_status: assert property (p_mcb_status) // RULE16
		else $error("blocking bit not cleared");

	property p_restore;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_RESTORE_DEFAULTS |=> ##1
			o_restore_defaults && !o_restart;
	endproperty
	a_restore: assert property (p_restore) // RULE6
		else $error("restore defaults not pulsed");

	property p_wait_off;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_WAIT_OFF |=> ##1
			status[usc_pkg::ST_NO_WAIT] && !poll_win;
	endproperty
	a_wait_off: assert property (p_wait_off) // RULE7
		else $error("waiting not switched off");

	property p_stop_pd;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_STOP_PD |=> ##1
			o_stop_pd && !o_load_pd_cfg;
	endproperty
	a_stop_pd: assert property (p_stop_pd) // RULE14
		else $error("process data not halted");

	property p_client_off;
		wr_cmd && key_ok && i_wdata == usc_pkg::CMD_CLIENT_OFF |=> ##1
			!o_discovery_client_en && o_discovery_server_en;
	endproperty
	a_client_off: assert property (p_client_off) // RULE15
		else $error("discovery client not disabled");

	c_keyed_cmd: cover property (wr_key ##1 wr_cmd && key_ok);
	c_block_port_b: cover property (mcb_r == usc_pkg::MCB_PORT_B && i_frame_valid[usc_pkg::PORT_B]);
	c_poll_window: cover property (wait_r && poll_win ##1 !poll_win);
	c_restart: cover property (o_restart);
	c_comm_request: cover property (req_s2_r && !wait_r ##1 o_comm_serve);

endmodule : usc_top

/* File: tb/usc_top_test.sv */
`timescale 1ns/1ps
module usc_top_test;
	localparam logic [19:0] A_KEY = {usc_pkg::IDX_UNLOCK_KEY, 2'b00};
	localparam logic [19:0] A_CMD = {usc_pkg::IDX_COMMAND_CODE, 2'b00};
	localparam logic [19:0] A_ST = {usc_pkg::IDX_SYSTEM_MODE_STATUS, 2'b00};
	localparam logic [19:0] A_BAD = 20'h00010;
	localparam logic [31:0] KEY = usc_pkg::UNLOCK_VALUE;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [19:0] i_addr = 20'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic i_comm_request = 1'b0;
	logic i_periph_busy = 1'b0;
	logic [2:0] i_frame_valid = 3'h0;
	logic [2:0][47:0] i_frame_dst = '0;
	logic [2:0][2:0] o_fwd_mask;
	logic [2:0] o_fwd_valid;
	logic o_restart, o_restore_defaults, o_load_module_cfg, o_load_pd_cfg, o_stop_pd;
	logic o_comm_serve, o_suspend_tasks, o_discovery_client_en, o_discovery_server_en;
	logic [4:0] seen = 5'h0;
	int pcy = 0;
	int err_total = 0;
	int tests_run = 0;
	logic [31:0] rv;
	usc_pkg::usc_mcb_e mode;
	logic [31:0] codes [20] = '{32'd161, 32'd160, 32'd122, 32'd123, 32'd330, 32'd331, 32'd411,
		32'd412, 32'd410, 32'd104, 32'd311, 32'd312, 32'd310, 32'd313, 32'd161, 32'd122,
		32'd330, 32'd411, 32'd102, 32'd999};
	logic [31:0] exps [20] = '{32'h5, 32'h4, 32'h6, 32'h4, 32'h0, 32'h4, 32'h104, 32'h104,
		32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h5, 32'h7, 32'h3, 32'h103, 32'h4, 32'h4};
	// pulse order: stop_pd, load_pd, load_module, restore, restart
	logic [4:0] pms [20] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h02,
		5'h04, 5'h08, 5'h0c, 5'h10, 5'h0, 5'h0, 5'h0, 5'h0, 5'h01, 5'h0};
	logic [47:0] dsts [5] = '{48'h01005e400000, 48'h01005e4000ff, 48'h01005e400100,
		48'h01005e3fffff, 48'h0a0b0c0d0e0f};

	usc_top #(.POLL_WIN_CYC(4), .POLL_PERIOD_CYC(16)) usc_top_inst (.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_comm_request(i_comm_request), .i_periph_busy(i_periph_busy),
		.i_frame_valid(i_frame_valid), .i_frame_dst(i_frame_dst), .o_fwd_mask(o_fwd_mask),
		.o_fwd_valid(o_fwd_valid), .o_restart(o_restart),
		.o_restore_defaults(o_restore_defaults), .o_load_module_cfg(o_load_module_cfg),
		.o_load_pd_cfg(o_load_pd_cfg), .o_stop_pd(o_stop_pd), .o_comm_serve(o_comm_serve),
		.o_suspend_tasks(o_suspend_tasks), .o_discovery_client_en(o_discovery_client_en),
		.o_discovery_server_en(o_discovery_server_en));

	always #50 i_ref_clk = ~i_ref_clk;

	wire [4:0] pulses = {o_stop_pd, o_load_pd_cfg, o_load_module_cfg, o_restore_defaults, o_restart};

	////////////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [19:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	task rd(input logic [19:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	task rd_chk(input logic [19:0] a, input logic [31:0] exp, input string what);
		rd(a, rv);
		chk(rv, exp, what);
	endtask : rd_chk

	task do_cmd(input logic [31:0] code, input logic [31:0] k);
		seen = 5'h0;
		pcy = 0;
		wr(A_KEY, k);
		wr(A_CMD, code);
		// pulses sampled every cycle so a one-cycle pulse is caught
		repeat (5) begin
			@(posedge i_ref_clk);
			#1;
			seen = seen | pulses;
			if (pulses != 5'h0)
				pcy++;
		end
	endtask : do_cmd

	task fwd_chk;
		logic [2:0] e;
		for (int k = 0; k < 5; k++) begin
			@(posedge i_ref_clk);
			i_frame_valid <= 3'h7;
			i_frame_dst <= {3{dsts[k]}};
			@(posedge i_ref_clk);
			i_frame_valid <= 3'h0;
			#1;
			chk(32'(o_fwd_valid), 32'h7, "fwd valid");
			for (int p = 0; p < 3; p++) begin
				e = ~(3'h1 << p);
				if (k < 2 && mode == usc_pkg::MCB_ALL)
					e = 3'h0;
				if (k < 2 && mode == usc_pkg::MCB_PORT_B)
					e = (p == 0) ? 3'h2 : (p == 1) ? 3'h1 : 3'h3;
				chk(32'(o_fwd_mask[p]), 32'(e), "fwd mask");
			end
		end
		@(posedge i_ref_clk);
		#1;
		chk(32'(o_fwd_valid), 32'h0, "fwd idle");
	endtask : fwd_chk

	task comm_chk(input logic waiting);
		int n;
		n = 0;
		repeat (20) @(posedge i_ref_clk);
		repeat (32) begin
			@(posedge i_ref_clk);
			#1;
			if (o_comm_serve === 1'b1)
				n++;
		end
		chk(32'(n), waiting ? 32'd8 : 32'd0, "poll window count");
		if (!waiting) begin
			@(posedge i_ref_clk);
			i_comm_request <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			#1;
			chk(32'(o_comm_serve), 32'h1, "serve on request");
			@(posedge i_ref_clk);
			i_comm_request <= 1'b0;
			repeat (4) @(posedge i_ref_clk);
			#1;
			chk(32'(o_comm_serve), 32'h0, "serve after request");
		end
	endtask : comm_chk

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#5000000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		mode = usc_pkg::MCB_OFF;
		repeat (3) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		rd_chk(A_ST, 32'h4, "reset status");
		rd_chk(A_KEY, 32'h0, "reset key");
		rd_chk(A_CMD, 32'h0, "reset command");
		wr(A_ST, 32'hffffffff);
		wr(A_BAD, 32'h12345678);
		rd_chk(A_ST, 32'h4, "status read only");
		rd_chk(A_BAD, 32'h0, "unmapped read");
		chk(32'(o_discovery_server_en), 32'h1, "server enable");
		fwd_chk();
		comm_chk(1'b1);
		// command without key, then with a wrong key
		#1;
		seen = 5'h0;
		wr(A_CMD, 32'd161);
		repeat (4) @(posedge i_ref_clk);
		rd_chk(A_CMD, 32'h0, "unkeyed command cleared");
		rd_chk(A_ST, 32'h4, "unkeyed status");
		do_cmd(32'd102, KEY ^ 32'h1);
		chk(32'(seen), 32'h0, "wrong key pulses");
		rd_chk(A_ST, 32'h4, "wrong key status");
		rd_chk(A_KEY, KEY ^ 32'h1, "wrong key kept");
		for (int i = 0; i < 20; i++) begin
			do_cmd(codes[i], KEY);
			if (codes[i] == 32'd411)
				mode = usc_pkg::MCB_ALL;
			if (codes[i] == 32'd412)
				mode = usc_pkg::MCB_PORT_B;
			if (codes[i] == 32'd410 || codes[i] == 32'd102)
				mode = usc_pkg::MCB_OFF;
			chk(32'(seen), 32'(pms[i]), "action pulses");
			chk(32'(pcy), (pms[i] != 5'h0) ? 32'd1 : 32'd0, "pulse length");
			rd_chk(A_ST, exps[i], "mode status");
			rd_chk(A_KEY, 32'h0, "key cleared");
			rd_chk(A_CMD, 32'h0, "command cleared");
			chk(32'(o_discovery_client_en), 32'(exps[i][2]), "client enable");
			@(posedge i_ref_clk);
			i_periph_busy <= 1'b1;
			@(negedge i_ref_clk);
			chk(32'(o_suspend_tasks), exps[i][0] ? 32'h0 : 32'h1, "suspend tasks");
			@(posedge i_ref_clk);
			i_periph_busy <= 1'b0;
			@(negedge i_ref_clk);
			chk(32'(o_suspend_tasks), 32'h0, "no suspend when idle");
			fwd_chk();
			comm_chk(~exps[i][1]);
		end
		// blocking on, then a reset in mid-run must turn it off again
		do_cmd(32'd411, KEY);
		rd_chk(A_ST, 32'h104, "blocking before reset");
		@(posedge i_ref_clk);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		mode = usc_pkg::MCB_OFF;
		rd_chk(A_ST, 32'h4, "status after reset");
		fwd_chk();
		test_done();
	end
endmodule : usc_top_test
